// file: sim/bml_host_model.sv
`timescale 1ns/1ps
module bml_host_model (
  input  wire logic clk_sys,  // Clock
  input  wire logic line_in,  // Pin level
  output logic      host_out = 1'b1, // Host drive
  output logic      host_oe  = 1'b0  // Host enable
);
  int bit_t = 256;
  // Bit 0 first
  task automatic send_frame(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      host_out <= f[i];
      host_oe  <= 1'b1;
      repeat (bit_t) @(posedge clk_sys);
    end
    host_oe  <= 1'b0;
    host_out <= 1'b1;
  endtask
  task automatic recv(output logic [7:0] b, output int gap, output int low_n);
    bit run;
    gap   = 0;
    low_n = 0;
    run   = 1'b1;
    b     = 8'h00;
    while (line_in !== 1'b0 && gap < 40000) begin
      @(posedge clk_sys);
      gap++;
    end
    for (int k = 0; k < 10 * bit_t + 4; k++) begin
      if (k % bit_t == bit_t / 2 && k / bit_t inside {[1:8]}) b[k / bit_t - 1] = line_in;
      run = run && (line_in === 1'b0);
      low_n += run;
      @(posedge clk_sys);
    end
  endtask
endmodule

// file: sim/bml_top_properties.sv
`timescale 1ns/1ps
module bml_top_chk
  import bml_pkg::*;
(
  input wire logic        clk_sys,            // Clock
  input wire logic        reset,              // Power-on reset
  input wire logic        sys_reset,          // Other reset
  input wire logic [2:0]  reg_addr,           // Reg address
  input wire logic [7:0]  reg_wdata,          // Reg data
  input wire logic        reg_wr,             // Write strobe
  input wire logic        reg_rd,             // Read strobe
  input wire logic [7:0]  reg_rdata,          // Read data
  input wire logic        cpu_addr_valid,     // Bus qualifier
  input wire logic        rti_done,           // Return done
  input wire logic        breakpoint_request, // Break out
  input wire logic [15:0] reset_vector_addr,  // Reset vector
  input wire logic [15:0] break_vector_addr,  // Break vector
  input wire logic        internal_reset,     // Extra reset
  input wire logic        monitor_mode,       // Monitor
  input wire logic        watchdog_disable,   // Watchdog off
  input wire logic        serial_pin_is_link, // Link pin
  input wire logic        porta_bit2_zero,    // Bit 2 zero
  input wire logic        irq_branch_enable,  // Branch enable
  input wire logic        serial_out,         // Tx level
  input wire logic        serial_oe           // Tx enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [9:0] oe_cnt_ff;
  // Drive age
  always_ff @(posedge clk_sys) begin
    if (reset || !serial_oe) begin
      oe_cnt_ff <= 10'h000;
    end else if (oe_cnt_ff != 10'h3FF) begin
      oe_cnt_ff <= oe_cnt_ff + 10'h001;
    end
  end
  a_arm_starts_break: assert property (
    reg_wr && reg_addr == REG_BRK_CTRL && reg_wdata[CTRL_ARM_BIT] && !sys_reset && !rti_done
    |=> breakpoint_request) else $error("arm write gave no break");
  a_rti_ends_break: assert property (
    rti_done && breakpoint_request && !cpu_addr_valid && !reg_wr |=> !breakpoint_request)
    else $error("break survived return");
  a_break_vector: assert property (
    break_vector_addr == (monitor_mode ? VEC_BREAK_MON : VEC_BREAK_USER))
    else $error("wrong break vector");
  a_reset_vector: assert property (
    reset_vector_addr == (monitor_mode ? VEC_RESET_MON : VEC_RESET_USER))
    else $error("wrong reset vector");
  a_blank_entry: assert property (
    $rose(internal_reset) |-> monitor_mode && watchdog_disable)
    else $error("blank entry wrong");
  a_extra_reset_len: assert property (
    $rose(internal_reset) |-> internal_reset [*8] ##1 !internal_reset)
    else $error("extra reset len");
  a_irq_not_port: assert property (
    monitor_mode |-> porta_bit2_zero && irq_branch_enable)
    else $error("irq pin still a port");
  a_link_pin: assert property (
    monitor_mode |-> serial_pin_is_link) else $error("serial pin not link");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside slot");
  a_echo_gap_high: assert property (
    serial_oe && oe_cnt_ff < 10'h100 |-> serial_out)
    else $error("no high gap before frame");
endmodule

bind bml_top bml_top_chk i_bml_top_chk (.*);

// file: sim/tb_bml_top.sv
`timescale 1ns/1ps
module tb_bml_top;
  import bml_pkg::*;
  logic        clk_sys, reset, sys_reset, reg_wr, reg_rd, cpu_addr_valid, rti_done, vec_fetch;
  logic        vec_low, irq_pin_level, use_internal_osc, serial_out, serial_oe, mem_wr, mem_rd;
  logic        breakpoint_request, internal_reset, monitor_mode, watchdog_disable, host_out;
  logic        ports_input_only, alt_clock_is_osc, serial_pin_is_link, porta_bit2_zero;
  logic        irq_branch_enable, run_request, host_oe, test_voltage;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, vec_data, mem_wdata, mem_rdata, wr_data;
  logic [15:0] cpu_addr, reset_vector_addr, break_vector_addr, mem_addr, rd_addr, wr_addr;
  int          fail_count, num_checks, cyc, rd_cyc, wr_n, run_n, bt, t_end;
  wire logic   serial_line = serial_oe ? serial_out : (host_oe ? host_out : 1'b1);

  bml_top i_bml_top (.*, .serial_in(serial_line), .cpu_sp(16'hABCD));
  bml_host_model i_bml_host_model (.clk_sys, .line_in(serial_line), .host_out, .host_oe);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Memory model, junk outside reads
  assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ 8'h5A) : 8'(cyc);
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (mem_rd) begin
      rd_addr <= mem_addr;
      rd_cyc  <= cyc;
    end
    if (mem_wr) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_n    <= wr_n + 1;
    end
    if (run_request) run_n <= run_n + 1;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    num_checks++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic por();
    reset <= 1'b1;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cpu_ev(input logic [15:0] a, input logic r);
    @(posedge clk_sys);
    cpu_addr       <= a;
    cpu_addr_valid <= !r;
    rti_done       <= r;
    @(posedge clk_sys);
    {cpu_addr_valid, rti_done} <= 2'h0;
    #1;
  endtask
  task automatic fetch(input logic lo);
    @(posedge clk_sys);
    vec_fetch <= 1'b1;
    vec_low   <= lo;
    vec_data  <= ERASED_BYTE;
    @(posedge clk_sys);
    vec_fetch <= 1'b0;
    #1;
  endtask
  task automatic t_reset_state();
    logic [7:0] d;
    for (int a = 0; a < 5; a++) begin
      rd(3'(a), d);
      chk("reg_reset", 16'h0000, 16'(d));
    end
    chk("rst_vec", VEC_RESET_USER, reset_vector_addr);
    chk("brk_vec", VEC_BREAK_USER, break_vector_addr);
    chk("mon_oe", 16'h0000, {14'h0000, monitor_mode, serial_oe});
  endtask
  task automatic t_break();
    logic [7:0] d;
    wr(REG_BRK_ADDR_HI, 8'h12);
    wr(REG_BRK_ADDR_LO, 8'h34);
    wr(REG_BRK_CTRL, 8'h80);
    cpu_ev(16'h1233, 1'b0);
    chk("miss", 16'h0000, 16'(breakpoint_request));
    cpu_ev(16'h1234, 1'b0);
    chk("hit", 16'h0001, 16'(breakpoint_request));
    rd(REG_MON_STATUS, d);
    chk("brk_stat", 16'h0001, 16'(d[STAT_BRK_BIT]));
    cpu_ev(16'h1234, 1'b1);
    chk("rti", 16'h0000, 16'(breakpoint_request));
    wr(REG_BRK_CTRL, 8'h00);
    cpu_ev(16'h1234, 1'b0);
    chk("disabled", 16'h0000, 16'(breakpoint_request));
    wr(REG_BRK_CTRL, 8'h40);
    chk("arm", 16'h0001, 16'(breakpoint_request));
    cpu_ev(16'h1234, 1'b1);
  endtask
  task automatic t_blank(input logic irq);
    int n;
    irq_pin_level <= irq;
    fetch(1'b0);
    fetch(1'b1);
    n = 0;
    while (internal_reset === 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("xrst_len", 16'h0008, 16'(n));
    chk("mon_vec", VEC_RESET_MON, reset_vector_addr);
    chk("mon_brk", VEC_BREAK_MON, break_vector_addr);
    chk("pins", {9'h000, 4'hF, irq, 2'h3}, {9'h000, monitor_mode, watchdog_disable,
      ports_input_only, serial_pin_is_link, alt_clock_is_osc, porta_bit2_zero,
      irq_branch_enable});
  endtask
  task automatic sys_rst(input logic tv, input logic [15:0] e);
    test_voltage <= tv;
    sys_reset    <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("mon_after_rst", e, 16'(monitor_mode));
  endtask
  task automatic xfer(input logic [7:0] b);
    logic [7:0] e;
    int         gap, lo;
    i_bml_host_model.send_frame({1'b1, b, 1'b0});
    i_bml_host_model.recv(e, gap, lo);
    chk("echo", 16'(b), 16'(e));
    chk_rng("echo_gap", bt / 2, 3 * bt, gap);
    t_end = cyc;
    repeat (2 * bt) @(posedge clk_sys);
  endtask
  task automatic rx_byte(input logic [7:0] x);
    logic [7:0] e;
    int         gap, lo;
    i_bml_host_model.recv(e, gap, lo);
    chk("data", 16'(x), 16'(e));
    repeat (2 * bt) @(posedge clk_sys);
  endtask
  task automatic wait_ev(ref int c, input int c0);
    for (int i = 0; i < 16 * bt && c == c0; i++) @(posedge clk_sys);
    chk("event", 16'(c0 + 1), 16'(c));
  endtask
  task automatic t_link();
    xfer(CMD_READ);
    xfer(8'h12);
    xfer(8'h34);
    rx_byte(8'h34 ^ 8'h5A);
    chk("rd_addr", 16'h1234, rd_addr);
    chk_rng("hold", 10 * bt, 13 * bt, rd_cyc - t_end);
    xfer(CMD_INDEXED_READ);
    rx_byte(8'h35 ^ 8'h5A);
    rx_byte(8'h36 ^ 8'h5A);
    xfer(CMD_READ_STACK_POINTER);
    rx_byte(8'hAB);
    rx_byte(8'hCD);
    xfer(CMD_WRITE);
    xfer(8'h00);
    xfer(8'h40);
    xfer(8'hA5);
    wait_ev(wr_n, wr_n);
    chk("wr", 16'h40A5, {wr_addr[7:0], wr_data});
    xfer(CMD_RUN);
    wait_ev(run_n, run_n);
  endtask
  task automatic t_link_break();
    logic [7:0] d;
    int         gap, lo, n0;
    bt = 335;
    i_bml_host_model.bit_t = bt;
    use_internal_osc <= 1'b1;
    repeat (4 * bt) @(posedge clk_sys);
    n0 = wr_n;
    xfer(CMD_INDEXED_WRITE);
    i_bml_host_model.send_frame(10'h000);
    i_bml_host_model.recv(d, gap, lo);
    chk_rng("brk_echo", 10 * bt - 4, 10 * bt + 4, lo);
    chk_rng("brk_gap", 0, 3 * bt, gap);
    repeat (14 * bt) @(posedge clk_sys);
    chk("cancel", 16'(n0), 16'(wr_n));
  endtask

  initial begin
    {reset, sys_reset, reg_wr, reg_rd, cpu_addr_valid, rti_done} = 6'h20;
    {vec_fetch, vec_low, irq_pin_level, use_internal_osc, test_voltage} = 5'h00;
    {reg_addr, reg_wdata, vec_data, cpu_addr} = 35'h0;
    bt = 256;
    por();
    t_reset_state();
    t_break();
    t_blank(1'b0);
    sys_rst(1'b0, 16'h0001);
    por();
    sys_rst(1'b1, 16'h0001);
    sys_rst(1'b0, 16'h0000);
    t_blank(1'b1);
    t_link();
    t_link_break();
    end_sim();
  end
  initial begin
    repeat (120000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end
endmodule

// file: verilog/bml_link_phy.sv
`timescale 1ns/1ps
module bml_link_phy (
  input  wire logic       clk_sys,   // System clock
  input  wire logic       reset,     // Sync reset
  input  wire logic [8:0] bit_div,   // Cycles per bit
  input  wire logic       rx_in,     // Serial pin level
  output logic            tx_out,    // Serial pin drive value
  output logic            tx_oe,     // Serial pin drive enable
  output logic            bit_tick,  // Free-running bit pulse
  output logic            rx_valid,  // Byte received pulse
  output logic [7:0]      rx_data,   // Received byte
  output logic            rx_break,  // Break received pulse
  input  wire logic       tx_go,     // Start gap plus frame
  input  wire logic       tx_break,  // Frame is a break
  input  wire logic [7:0] tx_data,   // Byte to send
  output logic            tx_busy    // Transmit in progress
);
  import bml_pkg::*;

  logic [8:0]         tick_cnt_ff;
  logic [8:0]         rx_cnt_ff;
  logic [3:0]         rx_idx_ff;
  logic               rx_act_ff;
  logic               rx_wait_ff;
  logic [7:0]         rx_sh_ff;
  logic [8:0]         tx_cnt_ff;
  logic [3:0]         tx_idx_ff;
  logic               tx_act_ff;
  logic [TX_BITS-1:0] tx_sh_ff;

  assign tx_busy = tx_act_ff | tx_go;
  assign tx_oe   = tx_act_ff;
  assign tx_out  = tx_sh_ff[0];

  always_ff @(posedge clk_sys) begin
    if (reset || tick_cnt_ff == 9'h000) begin
      tick_cnt_ff <= bit_div - 9'h001;
    end else begin
      tick_cnt_ff <= tick_cnt_ff - 9'h001;
    end
  end
  assign bit_tick = (tick_cnt_ff == 9'h000);

  // Receiver, mid-bit sampled, muted while sending
  always_ff @(posedge clk_sys) begin
    rx_valid <= 1'b0;
    rx_break <= 1'b0;
    if (reset) begin
      rx_act_ff  <= 1'b0;
      rx_wait_ff <= 1'b0;
      rx_cnt_ff  <= 9'h000;
      rx_idx_ff  <= 4'h0;
      rx_sh_ff   <= 8'h00;
      rx_data    <= 8'h00;
    end else if (rx_wait_ff) begin
      rx_wait_ff <= ~rx_in;
    end else if (!rx_act_ff) begin
      if (!tx_busy && !rx_in) begin
        rx_act_ff <= 1'b1;
        rx_idx_ff <= 4'h0;
        rx_cnt_ff <= {1'b0, bit_div[8:1]};
      end
    end else if (rx_cnt_ff != 9'h000) begin
      rx_cnt_ff <= rx_cnt_ff - 9'h001;
    end else begin
      rx_cnt_ff <= bit_div - 9'h001;
      rx_idx_ff <= rx_idx_ff + 4'h1;
      if (rx_idx_ff == 4'h0) begin
        rx_act_ff <= ~rx_in;
      end else if (rx_idx_ff < 4'(RX_LAST_IDX)) begin
        rx_sh_ff <= {rx_in, rx_sh_ff[7:1]};
      end else begin
        rx_act_ff <= 1'b0;
        if (rx_in) begin
          rx_valid <= 1'b1;
          rx_data  <= rx_sh_ff;
        end else if (rx_sh_ff == 8'h00) begin
          rx_break   <= 1'b1;
          rx_wait_ff <= 1'b1;
        end
      end
    end
  end

  // Two high bits, then frame or ten lows
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_act_ff <= 1'b0;
      tx_sh_ff  <= '1;
      tx_cnt_ff <= 9'h000;
      tx_idx_ff <= 4'h0;
    end else if (!tx_act_ff) begin
      if (tx_go) begin
        tx_act_ff <= 1'b1;
        tx_cnt_ff <= bit_div - 9'h001;
        tx_idx_ff <= 4'h0;
        tx_sh_ff  <= tx_break ? {1'b1, 10'h000, 2'h3}
                              : {2'h3, tx_data, 1'b0, 2'h3};
      end
    end else if (tx_cnt_ff != 9'h000) begin
      tx_cnt_ff <= tx_cnt_ff - 9'h001;
    end else begin
      tx_cnt_ff <= bit_div - 9'h001;
      tx_sh_ff  <= {1'b1, tx_sh_ff[TX_BITS-1:1]};
      tx_idx_ff <= tx_idx_ff + 4'h1;
      if (tx_idx_ff == 4'(TX_BITS - 1)) begin
        tx_act_ff <= 1'b0;
      end
    end
  end
endmodule

// file: verilog/bml_pkg.sv
package bml_pkg;
  // Register port
  localparam int          REG_AW          = 3;
  localparam int          REG_DW          = 8;
  localparam logic [2:0]  REG_BRK_ADDR_HI = 3'h0;
  localparam logic [2:0]  REG_BRK_ADDR_LO = 3'h1;
  localparam logic [2:0]  REG_BRK_CTRL    = 3'h2;
  localparam logic [2:0]  REG_MON_STATUS  = 3'h3;
  localparam int          CTRL_ENABLE_BIT = 7;
  localparam int          CTRL_ARM_BIT    = 6;
  localparam int          STAT_MON_BIT    = 0;
  localparam int          STAT_FORCED_BIT = 1;
  localparam int          STAT_IRQ_BIT    = 2;
  localparam int          STAT_BRK_BIT    = 3;
  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;

  // Vectors
  localparam logic [15:0] VEC_RESET_USER  = 16'hFFFE;
  localparam logic [15:0] VEC_RESET_MON   = 16'hFEFE;
  localparam logic [15:0] VEC_BREAK_USER  = 16'hFFFC;
  localparam logic [15:0] VEC_BREAK_MON   = 16'hFEFC;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;

  // Link timing, dividers in cycles per bit, extra reset in cycles
  localparam logic [8:0]  DIV_EXT_OSC     = 9'h100;
  localparam logic [8:0]  DIV_INT_OSC     = 9'h14F;
  localparam logic [3:0]  HOLD_BITS       = 4'hB;
  localparam int          TX_BITS         = 13;
  localparam int          RX_LAST_IDX     = 9;
  localparam logic [3:0]  EXTRA_RST_CYC   = 4'h8;

  // Command codes, values arbitrary
  localparam logic [7:0]  CMD_READ        = 8'h01;
  localparam logic [7:0]  CMD_WRITE       = 8'h02;
  localparam logic [7:0]  CMD_INDEXED_READ       = 8'h03;
  localparam logic [7:0]  CMD_INDEXED_WRITE      = 8'h04;
  localparam logic [7:0]  CMD_READ_STACK_POINTER      = 8'h05;
  localparam logic [7:0]  CMD_RUN         = 8'h06;

  typedef enum logic [2:0] {
    ST_CMD, ST_ECHO, ST_HOLD, ST_EXEC, ST_FETCH, ST_SEND, ST_SENDW, ST_BRK
  } bml_state_type;
endpackage

// file: verilog/bml_top.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module bml_top (
  input  wire logic        clk_sys,          // 40 MHz clock
  input  wire logic        reset,            // Power-on reset
  input  wire logic        sys_reset,        // Any other reset
  input  wire logic [2:0]  reg_addr,         // Register address
  input  wire logic [7:0]  reg_wdata,        // Register write data
  input  wire logic        reg_wr,           // Register write strobe
  input  wire logic        reg_rd,           // Register read strobe
  output logic      [7:0]  reg_rdata,        // Register read data
  input  wire logic [15:0] cpu_addr,         // Internal address bus
  input  wire logic        cpu_addr_valid,   // Address bus qualifier
  input  wire logic        rti_done,         // Interrupt return executed
  output logic             breakpoint_request, // To integration unit
  input  wire logic        vec_fetch,        // Reset vector byte fetched
  input  wire logic [7:0]  vec_data,         // Fetched vector byte
  input  wire logic        vec_low,          // Fetch is low byte
  output logic [15:0]      reset_vector_addr, // Reset vector pair base
  output logic [15:0]      break_vector_addr, // Break and swi vector base
  output logic             internal_reset,   // Extra reset request
  input  wire logic        test_voltage,     // Test voltage on irq pin
  input  wire logic        irq_pin_level,    // Irq pin level
  input  wire logic        use_internal_osc, // Internal oscillator in use
  output logic             monitor_mode,     // Monitor mode active
  output logic             watchdog_disable, // Watchdog held off
  output logic             ports_input_only, // Pins forced to inputs
  output logic             alt_clock_is_osc, // Clock pin as oscillator
  output logic             serial_pin_is_link, // Serial pin is link
  output logic             porta_bit2_zero,  // Port bit 2 reads zero
  output logic             irq_branch_enable, // Branch on irq pin active
  input  wire logic        serial_in,        // Serial pin input
  output logic             serial_out,       // Serial pin output
  output logic             serial_oe,        // Serial pin drive enable
  output logic [15:0]      mem_addr,         // Memory address
  output logic [7:0]       mem_wdata,        // Memory write data
  output logic             mem_wr,           // Memory write strobe
  output logic             mem_rd,           // Memory read strobe
  input  wire logic [7:0]  mem_rdata,        // Memory data, same cycle as mem_rd
  input  wire logic [15:0] cpu_sp,           // Stack pointer value
  output logic             run_request       // Run user program pulse
);
  import bml_pkg::*;

  function automatic logic [2:0] cmd_len(input logic [7:0] c);
    unique case (c)
      CMD_READ:   cmd_len = 3'h3;
      CMD_WRITE:  cmd_len = 3'h4;
      CMD_INDEXED_WRITE: cmd_len = 3'h2;
      default:    cmd_len = 3'h1;
    endcase
  endfunction

  function automatic logic [1:0] reply_len(input logic [7:0] c);
    unique case (c)
      CMD_READ:   reply_len = 2'h1;
      CMD_INDEXED_READ:  reply_len = 2'h2;
      CMD_READ_STACK_POINTER: reply_len = 2'h2;
      default:    reply_len = 2'h0;
    endcase
  endfunction

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c == CMD_READ) || (c == CMD_WRITE) || (c == CMD_INDEXED_READ) ||
                (c == CMD_INDEXED_WRITE) || (c == CMD_READ_STACK_POINTER) || (c == CMD_RUN);
  endfunction

  // Break unit
  logic [7:0]  brk_hi_ff;
  logic [7:0]  brk_lo_ff;
  logic        brk_en_ff;
  logic        brk_act_ff;
  logic        addr_match;

  // Mode control
  logic        forced_ff;
  logic        tst_mon_ff;
  logic        blank_hi_ff;
  logic [3:0]  xrst_cnt_ff;
  logic        in_reset_ff;

  // Link engine
  bml_state_type state_ff;
  logic [7:0]  buf_ff [4];
  logic [2:0]  idx_ff;
  logic [1:0]  reply_ff;
  logic [3:0]  hold_ff;
  logic [15:0] ptr_ff;
  logic        sp_lo_ff;
  logic [7:0]  tx_data_ff;
  logic        tx_go_ff;
  logic        tx_brk_ff;
  logic        bit_tick;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_break;
  logic        tx_busy;
  logic [8:0]  bit_div;
  logic [15:0] cmd_addr;

  assign addr_match = brk_en_ff && cpu_addr_valid && (cpu_addr == {brk_hi_ff, brk_lo_ff});
  assign cmd_addr   = {buf_ff[1], buf_ff[2]};

  // Break registers and request
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      brk_hi_ff <= REG_RESET_VAL;
      brk_lo_ff <= REG_RESET_VAL;
      brk_en_ff <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_BRK_ADDR_HI: brk_hi_ff <= reg_wdata;
        REG_BRK_ADDR_LO: brk_lo_ff <= reg_wdata;
        REG_BRK_CTRL:    brk_en_ff <= reg_wdata[CTRL_ENABLE_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || sys_reset) begin
      brk_act_ff <= 1'b0;
    end else if (addr_match) begin
      brk_act_ff <= 1'b1;
    end else if (reg_wr && reg_addr == REG_BRK_CTRL && reg_wdata[CTRL_ARM_BIT]) begin
      brk_act_ff <= 1'b1;
    end else if (rti_done) begin
      brk_act_ff <= 1'b0;
    end
  end
  assign breakpoint_request = brk_act_ff;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_BRK_ADDR_HI: reg_rdata <= brk_hi_ff;
        REG_BRK_ADDR_LO: reg_rdata <= brk_lo_ff;
        REG_BRK_CTRL: begin
          reg_rdata <= 8'h00;
          reg_rdata[CTRL_ENABLE_BIT] <= brk_en_ff;
          reg_rdata[CTRL_ARM_BIT]    <= brk_act_ff;
        end
        REG_MON_STATUS: begin
          reg_rdata <= 8'h00;
          reg_rdata[STAT_MON_BIT]    <= monitor_mode;
          reg_rdata[STAT_FORCED_BIT] <= forced_ff;
          reg_rdata[STAT_IRQ_BIT]    <= irq_pin_level;
          reg_rdata[STAT_BRK_BIT]    <= brk_act_ff;
        end
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Blank reset vector detection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      forced_ff   <= 1'b0;
      blank_hi_ff <= 1'b0;
      xrst_cnt_ff <= 4'h0;
    end else begin
      if (xrst_cnt_ff != 4'h0) begin
        xrst_cnt_ff <= xrst_cnt_ff - 4'h1;
      end
      if (vec_fetch && !monitor_mode) begin
        if (!vec_low) begin
          blank_hi_ff <= (vec_data == ERASED_BYTE);
        end else if (blank_hi_ff && vec_data == ERASED_BYTE) begin
          forced_ff   <= 1'b1;
          xrst_cnt_ff <= EXTRA_RST_CYC;
        end
      end
    end
  end
  assign internal_reset = (xrst_cnt_ff != 4'h0);

  // Test voltage sampled at each reset release
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_reset_ff <= 1'b1;
      tst_mon_ff  <= 1'b0;
    end else begin
      in_reset_ff <= sys_reset | internal_reset;
      if (in_reset_ff && !(sys_reset | internal_reset)) begin
        tst_mon_ff <= test_voltage;
      end
    end
  end

  assign monitor_mode       = forced_ff | tst_mon_ff;
  assign reset_vector_addr  = monitor_mode ? VEC_RESET_MON : VEC_RESET_USER;
  assign break_vector_addr  = monitor_mode ? VEC_BREAK_MON : VEC_BREAK_USER;
  assign watchdog_disable   = forced_ff | brk_act_ff;
  assign ports_input_only   = forced_ff;
  assign alt_clock_is_osc   = forced_ff & irq_pin_level;
  assign serial_pin_is_link = monitor_mode;
  assign porta_bit2_zero    = monitor_mode;
  assign irq_branch_enable  = monitor_mode;
  assign bit_div = (forced_ff && use_internal_osc) ? DIV_INT_OSC : DIV_EXT_OSC;

  bml_link_phy i_bml_link_phy (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .bit_div  (bit_div),
    .rx_in    (serial_in),
    .tx_out   (serial_out),
    .tx_oe    (serial_oe),
    .bit_tick (bit_tick),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_break (rx_break),
    .tx_go    (tx_go_ff),
    .tx_break (tx_brk_ff),
    .tx_data  (tx_data_ff),
    .tx_busy  (tx_busy)
  );

  // Command engine
  always_ff @(posedge clk_sys) begin
    tx_go_ff    <= 1'b0;
    mem_wr      <= 1'b0;
    mem_rd      <= 1'b0;
    run_request <= 1'b0;
    if (reset || !monitor_mode) begin
      state_ff   <= ST_CMD;
      idx_ff     <= 3'h0;
      reply_ff   <= 2'h0;
      hold_ff    <= 4'h0;
      ptr_ff     <= 16'h0000;
      sp_lo_ff   <= 1'b0;
      tx_data_ff <= 8'h00;
      tx_brk_ff  <= 1'b0;
      mem_addr   <= 16'h0000;
      mem_wdata  <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        buf_ff[i] <= 8'h00;
      end
    end else if (rx_break) begin
      state_ff  <= ST_BRK;
      tx_go_ff  <= 1'b1;
      tx_brk_ff <= 1'b1;
      idx_ff    <= 3'h0;
    end else begin
      unique case (state_ff)
        ST_CMD: begin
          if (rx_valid && (idx_ff != 3'h0 || known_cmd(rx_data))) begin
            buf_ff[idx_ff[1:0]] <= rx_data;
            tx_data_ff <= rx_data;
            tx_brk_ff  <= 1'b0;
            tx_go_ff   <= 1'b1;
            state_ff   <= ST_ECHO;
          end else if (rx_valid) begin
            tx_data_ff <= rx_data;
            tx_brk_ff  <= 1'b0;
            tx_go_ff   <= 1'b1;
            state_ff   <= ST_BRK;
          end
        end
        ST_ECHO: begin
          if (!tx_busy) begin
            if (idx_ff + 3'h1 == cmd_len(buf_ff[0])) begin
              hold_ff  <= 4'h0;
              state_ff <= ST_HOLD;
            end else begin
              idx_ff   <= idx_ff + 3'h1;
              state_ff <= ST_CMD;
            end
          end
        end
        ST_HOLD: begin
          if (bit_tick) begin
            hold_ff <= hold_ff + 4'h1;
            if (hold_ff + 4'h1 == HOLD_BITS) begin
              state_ff <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          reply_ff <= reply_len(buf_ff[0]);
          sp_lo_ff <= 1'b0;
          idx_ff   <= 3'h0;
          state_ff <= ST_FETCH;
          unique case (buf_ff[0])
            CMD_READ: ptr_ff <= cmd_addr;
            CMD_WRITE: begin
              mem_addr  <= cmd_addr;
              mem_wdata <= buf_ff[3];
              mem_wr    <= 1'b1;
              ptr_ff    <= cmd_addr + 16'h0001;
            end
            CMD_INDEXED_WRITE: begin
              mem_addr  <= ptr_ff;
              mem_wdata <= buf_ff[1];
              mem_wr    <= 1'b1;
              ptr_ff    <= ptr_ff + 16'h0001;
            end
            CMD_RUN: run_request <= 1'b1;
            default: ;
          endcase
        end
        ST_FETCH: begin
          if (reply_ff == 2'h0) begin
            state_ff <= ST_CMD;
          end else begin
            mem_addr <= ptr_ff;
            mem_rd   <= (buf_ff[0] != CMD_READ_STACK_POINTER);
            state_ff <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (buf_ff[0] == CMD_READ_STACK_POINTER) begin
            tx_data_ff <= sp_lo_ff ? cpu_sp[7:0] : cpu_sp[15:8];
            sp_lo_ff   <= 1'b1;
          end else begin
            tx_data_ff <= mem_rdata;
            ptr_ff     <= ptr_ff + 16'h0001;
          end
          tx_brk_ff <= 1'b0;
          tx_go_ff  <= 1'b1;
          reply_ff  <= reply_ff - 2'h1;
          state_ff  <= ST_SENDW;
        end
        ST_SENDW: begin
          if (!tx_busy) begin
            state_ff <= ST_FETCH;
          end
        end
        ST_BRK: begin
          if (!tx_busy) begin
            idx_ff   <= 3'h0;
            state_ff <= ST_CMD;
          end
        end
        default: state_ff <= ST_CMD;
      endcase
    end
  end
endmodule
